// ==== hdl/dcc_pkg.sv ====
// Constants for the dual comparator control block.
// Assumes an 8-bit special-function-register bus and one system clock.
package dcc_pkg;

  // ----------------------------------------------------------------
  // Register addresses, index 0 is the first comparator
  // ----------------------------------------------------------------
  localparam int DCC_NUM = 2;
  localparam logic [1:0][7:0] DCC_CTRL_ADDR = {8'h9a, 8'h9b};
  localparam logic [1:0][7:0] DCC_MODE_ADDR = {8'h9c, 8'h9d};
  localparam logic [1:0][7:0] DCC_MUX_ADDR = {8'h9e, 8'h9f};

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int DCC_ON_BIT = 7;
  localparam int DCC_RESULT_BIT = 6;
  localparam int DCC_RISE_BIT = 5;
  localparam int DCC_FALL_BIT = 4;
  localparam int DCC_HYP_LSB = 2;
  localparam int DCC_HYN_LSB = 0;
  localparam logic [7:0] DCC_CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Mode and mux register fields
  // ----------------------------------------------------------------
  localparam int DCC_RIE_BIT = 5;
  localparam int DCC_FIE_BIT = 4;
  localparam int DCC_SPEED_LSB = 0;
  localparam logic [7:0] DCC_MODE_RESET = 8'h02;
  localparam logic [7:0] DCC_MODE_MASK = 8'h33;
  localparam int DCC_MINUS_LSB = 4;
  localparam int DCC_PLUS_LSB = 0;
  localparam logic [7:0] DCC_MUX_RESET = 8'h00;
  localparam logic [7:0] DCC_MUX_MASK = 8'h33;
  localparam logic [1:0] DCC_SEL_RESERVED = 2'h3;

endpackage

// ==== hdl/dcc_top.sv ====
// Digital control and status of two programmable voltage comparators.
// Assumes the analog comparators deliver their results asynchronously
// and that software reaches the registers over the SFR bus below.
// Assumes one system clock and an asynchronous, active-low chip reset.
`timescale 1ns/1ps
module dcc_top
  import dcc_pkg::*;
#(
  parameter bit SMALL_PKG = 1'b0
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Special-function-register bus
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WE,
  input wire logic SFR_RE,
  output logic [7:0] SFR_RDATA,
  // Analog comparator results, asynchronous
  input wire logic [1:0] COMP_RAW,
  // Analog front-end controls
  output logic [1:0] COMP_ON,
  output logic [3:0] POS_HYSTERESIS_SEL,
  output logic [3:0] NEG_HYSTERESIS_SEL,
  output logic [3:0] PLUS_INPUT_SEL,
  output logic [3:0] MINUS_INPUT_SEL,
  output logic [3:0] RESPONSE_SPEED_SEL,
  // Outputs towards the pins and the interrupt and reset logic
  output logic [1:0] LATCHED_RESULT_OUT,
  output logic [1:0] RAW_RESULT_OUT,
  output logic [1:0] RISE_IRQ,
  output logic [1:0] FALL_IRQ,
  output logic COMP_RESET_REQ
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [1:0][7:0] ctrl_reg;
  logic [1:0][7:0] mode_reg;
  logic [1:0][7:0] mux_reg;
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] prev_reg;
  logic [1:0] latched_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // ----------------------------------------------------------------
  // Per-comparator registers and edge detection
  // ----------------------------------------------------------------
  // Both instances come from one loop so they cannot drift apart.
  generate
    for (genvar i = 0; i < DCC_NUM; i++)
    begin : g_comp
      logic [7:0] ctrl_next;
      logic [7:0] mode_next;
      logic [7:0] mux_next;
      logic [1:0] plus_sel;
      logic [1:0] minus_sel;
      logic rise_evt;
      logic fall_evt;
      logic latched_next;

      always_comb
      begin
        // Edges are judged on the second synchroniser stage against its last sample gated by the enable bit.
        rise_evt = ctrl_reg[i][DCC_ON_BIT] & sync2_reg[i] & ~prev_reg[i];
        fall_evt = ctrl_reg[i][DCC_ON_BIT] & ~sync2_reg[i] & prev_reg[i];
        ctrl_next = ctrl_reg[i];
        mode_next = mode_reg[i];
        mux_next = mux_reg[i];
        if (SFR_WE && SFR_ADDR == DCC_CTRL_ADDR[i])
        begin
          ctrl_next = SFR_WDATA;
          // The result bit is not storage; reads replace it with the latched result.
          ctrl_next[DCC_RESULT_BIT] = 1'b0;
        end
        if (SFR_WE && SFR_ADDR == DCC_MODE_ADDR[i])
        begin
          // Unused bits are dropped here so they always read back as zero.
          mode_next = SFR_WDATA & DCC_MODE_MASK;
        end
        if (SFR_WE && SFR_ADDR == DCC_MUX_ADDR[i])
        begin
          mux_next = SFR_WDATA & DCC_MUX_MASK;
        end
        // A set in the same cycle as a software clear wins, so no edge is lost.
        ctrl_next[DCC_RISE_BIT] = ctrl_next[DCC_RISE_BIT] | rise_evt;
        ctrl_next[DCC_FALL_BIT] = ctrl_next[DCC_FALL_BIT] | fall_evt;
        latched_next = sync2_reg[i] & ctrl_reg[i][DCC_ON_BIT];
        // On the small package the fourth pin is absent, so code 3 selects the first.
        // Software still reads back the code it wrote; only the analog mux sees the change.
        plus_sel = mux_reg[i][DCC_PLUS_LSB +: 2];
        minus_sel = mux_reg[i][DCC_MINUS_LSB +: 2];
        if (SMALL_PKG && plus_sel == DCC_SEL_RESERVED)
        begin
          plus_sel = 2'h0;
        end
        if (SMALL_PKG && minus_sel == DCC_SEL_RESERVED)
        begin
          minus_sel = 2'h0;
        end
      end

      always_ff @(posedge CLK or negedge RSTN)
      begin
        if (!RSTN)
        begin
          ctrl_reg[i] <= DCC_CTRL_RESET;
          mode_reg[i] <= DCC_MODE_RESET;
          mux_reg[i] <= DCC_MUX_RESET;
          sync1_reg[i] <= 1'b0;
          sync2_reg[i] <= 1'b0;
          prev_reg[i] <= 1'b0;
          latched_reg[i] <= 1'b0;
        end
        else
        begin
          ctrl_reg[i] <= ctrl_next;
          mode_reg[i] <= mode_next;
          mux_reg[i] <= mux_next;
          // Two stages, because the analog result may change at any moment.
          sync1_reg[i] <= COMP_RAW[i];
          sync2_reg[i] <= sync1_reg[i];
          // Gated like the latched output, so a high level held while off flags a rise once switched on.
          prev_reg[i] <= latched_next;
          latched_reg[i] <= latched_next;
        end
      end

      // ----------------------------------------------------------------
      // Front-end controls and outputs
      // ----------------------------------------------------------------
      assign COMP_ON[i] = ctrl_reg[i][DCC_ON_BIT];
      assign POS_HYSTERESIS_SEL[2*i +: 2] = ctrl_reg[i][DCC_HYP_LSB +: 2];
      assign NEG_HYSTERESIS_SEL[2*i +: 2] = ctrl_reg[i][DCC_HYN_LSB +: 2];
      assign PLUS_INPUT_SEL[2*i +: 2] = plus_sel;
      assign MINUS_INPUT_SEL[2*i +: 2] = minus_sel;
      assign RESPONSE_SPEED_SEL[2*i +: 2] = mode_reg[i][DCC_SPEED_LSB +: 2];
      assign LATCHED_RESULT_OUT[i] = latched_reg[i];
      // The raw path has no flip-flop so it keeps working with the clock stopped.
      assign RAW_RESULT_OUT[i] = COMP_RAW[i] & ctrl_reg[i][DCC_ON_BIT];
      // Each edge keeps its own request so the handler can tell them apart.
      assign RISE_IRQ[i] = ctrl_reg[i][DCC_RISE_BIT] & mode_reg[i][DCC_RIE_BIT];
      assign FALL_IRQ[i] = ctrl_reg[i][DCC_FALL_BIT] & mode_reg[i][DCC_FIE_BIT];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Reset source
  // ----------------------------------------------------------------
  // Only the first comparator feeds the reset logic.
  assign COMP_RESET_REQ = latched_reg[0];

  // ----------------------------------------------------------------
  // Read data, registered one cycle after the read strobe
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_next = rdata_reg;
    if (SFR_RE)
    begin
      // Unmapped addresses read as zero rather than whatever was read last.
      rdata_next = 8'h00;
      for (int k = 0; k < DCC_NUM; k++)
      begin
        if (SFR_ADDR == DCC_CTRL_ADDR[k])
        begin
          rdata_next = ctrl_reg[k];
          rdata_next[DCC_RESULT_BIT] = latched_reg[k];
        end
        if (SFR_ADDR == DCC_MODE_ADDR[k])
        begin
          rdata_next = mode_reg[k];
        end
        if (SFR_ADDR == DCC_MUX_ADDR[k])
        begin
          rdata_next = mux_reg[k];
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      // The byte holds between reads, so a slow reader still sees it.
      rdata_reg <= rdata_next;
    end
  end

  assign SFR_RDATA = rdata_reg;

endmodule

// ==== dv/dcc_analog_model.sv ====
// Model of the two analog comparators that sit behind the input pins.
// Assumes the bench sets pin levels; results are meaningless while off.
`timescale 1ns/1ps
module dcc_analog_model
  import dcc_pkg::*;
(
  // Enables, pin levels and results
  input wire logic [1:0] comp_on,
  input wire logic [15:0] vp,
  input wire logic [15:0] vn,
  output logic [1:0] comp_raw
);
  // A switched-off comparator gives noise, so gating must be done inside.
  always_comb
  begin
    for (int i = 0; i < DCC_NUM; i++)
    begin
      comp_raw[i] = comp_on[i] ? vp[8*i+:8] > vn[8*i+:8] : vp[8*i] ^ vn[8*i];
    end
  end
endmodule

// ==== dv/dcc_properties.sv ====
// Concurrent checks on the comparator control ports.
// Assumes it is bound to every dcc_top instance.
`timescale 1ns/1ps
module dcc_properties
  import dcc_pkg::*;
(
  // Watched ports
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WE,
  input wire logic SFR_RE,
  input wire logic [7:0] SFR_RDATA,
  input wire logic [1:0] COMP_RAW,
  input wire logic [1:0] COMP_ON,
  input wire logic [3:0] POS_HYSTERESIS_SEL,
  input wire logic [3:0] NEG_HYSTERESIS_SEL,
  input wire logic [1:0] LATCHED_RESULT_OUT,
  input wire logic [1:0] RAW_RESULT_OUT,
  input wire logic [1:0] RISE_IRQ,
  input wire logic [1:0] FALL_IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence wr0; SFR_WE && SFR_ADDR == DCC_CTRL_ADDR[0]; endsequence
  sequence rd0; SFR_RE && !SFR_WE && SFR_ADDR == DCC_CTRL_ADDR[0]; endsequence
  raw_gate_a: assert property (RAW_RESULT_OUT == (COMP_RAW & COMP_ON))
    else $error("raw output not gated");
  latch_delay_a: assert property (COMP_ON[0] [*3] |=>
    LATCHED_RESULT_OUT[0] == $past(COMP_RAW[0], 3)) else $error("latched result late");
  ctrl_write_a: assert property (wr0 |=> COMP_ON[0] == $past(SFR_WDATA[7]) &&
    {POS_HYSTERESIS_SEL[1:0], NEG_HYSTERESIS_SEL[1:0]} == $past(SFR_WDATA[3:0]))
    else $error("control write lost");
  ctrl_read_a: assert property (rd0 |=> SFR_RDATA[7] == $past(COMP_ON[0]) &&
    SFR_RDATA[6] == $past(LATCHED_RESULT_OUT[0])) else $error("control read wrong");
  rise_hold_a: assert property (RISE_IRQ[0] && !SFR_WE |=> RISE_IRQ[0])
    else $error("rise flag lost");
  fall_hold_a: assert property (FALL_IRQ[1] && !SFR_WE |=> FALL_IRQ[1])
    else $error("fall flag lost");
  rise_cause_a: assert property ($rose(RISE_IRQ[0]) |-> $rose(LATCHED_RESULT_OUT[0])
    || $past(SFR_WE)) else $error("rise irq without edge");
  fall_cause_a: assert property ($rose(FALL_IRQ[0]) |-> $fell(LATCHED_RESULT_OUT[0])
    || $past(SFR_WE)) else $error("fall irq without edge");
endmodule
bind dcc_top dcc_properties u_dcc_properties (.*);

// ==== dv/tb.sv ====
// Self-checking bench for the dual comparator control block.
// Assumes the analog model drives COMP_RAW from the bench pin levels.
`timescale 1ns/1ps
module tb;
  import dcc_pkg::*;
  logic CLK = 0, RSTN = 0, SFR_WE = 0, SFR_RE = 0, COMP_RESET_REQ;
  logic [7:0] SFR_ADDR = 0, SFR_WDATA = 0, SFR_RDATA, hy;
  logic [15:0] vp = 0, vn = 0;
  logic [1:0] COMP_RAW, COMP_ON, LATCHED_RESULT_OUT, RAW_RESULT_OUT, RISE_IRQ, FALL_IRQ;
  logic [3:0] POS_HYSTERESIS_SEL, NEG_HYSTERESIS_SEL, PLUS_INPUT_SEL, MINUS_INPUT_SEL;
  logic [3:0] RESPONSE_SPEED_SEL;
  int bad_count = 0, total_checks = 0, cyc = 0;
  dcc_top #(.SMALL_PKG(1'b1)) u_dcc_top (.*);
  dcc_analog_model u_dcc_analog_model (.comp_on(COMP_ON), .vp(vp), .vn(vn), .comp_raw(COMP_RAW));
  initial forever #20 CLK = ~CLK;
  function automatic logic [7:0] ctl(logic res, logic r, logic f, logic [3:0] h);
    return {1'b1, res, r, f, h};
  endfunction
  function automatic logic [7:0] st(int i);
    return {4'h0, RISE_IRQ[i], FALL_IRQ[i], LATCHED_RESULT_OUT[i], RAW_RESULT_OUT[i]};
  endfunction
  // The bench builds the small package, where the reserved code falls back to the first pin.
  function automatic logic [1:0] pin(logic [1:0] c);
    return (c == DCC_SEL_RESERVED) ? 2'h0 : c;
  endfunction
  task automatic conclude();
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // A strobe is dropped for one edge so back-to-back calls never overlap.
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    SFR_WE <= w;
    SFR_RE <= !w;
    SFR_ADDR <= a;
    SFR_WDATA <= d;
    @(posedge CLK);
    SFR_WE <= 0;
    SFR_RE <= 0;
    @(posedge CLK);
  endtask
  task automatic rc(logic [7:0] a, logic [7:0] e, string n);
    acc(0, a, 8'h00);
    chk(n, e, SFR_RDATA);
  endtask
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      bad_count++;
      conclude();
    end
  end
  initial
  begin
    hy = 8'($urandom(65943));
    repeat (20) @(posedge CLK);
    RSTN <= 1;
    chk("speed", {4'h0, DCC_MODE_RESET[1:0], DCC_MODE_RESET[1:0]},
      {4'h0, RESPONSE_SPEED_SEL});
    for (int i = 0; i < DCC_NUM; i++)
    begin
      rc(DCC_CTRL_ADDR[i], DCC_CTRL_RESET, "control");
      rc(DCC_MODE_ADDR[i], DCC_MODE_RESET, "mode");
      rc(DCC_MUX_ADDR[i], DCC_MUX_RESET, "mux");
    end
    for (int i = 0; i < DCC_NUM; i++)
    begin
      hy = 8'($urandom);
      acc(1, DCC_CTRL_ADDR[i], {4'h8, hy[3:0]});
      chk("hyst", {4'h0, hy[3:0]},
        {4'h0, POS_HYSTERESIS_SEL[2*i+:2], NEG_HYSTERESIS_SEL[2*i+:2]});
      acc(1, DCC_MUX_ADDR[i], hy);
      rc(DCC_MUX_ADDR[i], hy & DCC_MUX_MASK, "mux");
      chk("pins", {4'h0, pin(hy[1:0]), pin(hy[5:4])},
        {4'h0, PLUS_INPUT_SEL[2*i+:2], MINUS_INPUT_SEL[2*i+:2]});
      acc(1, DCC_MUX_ADDR[i], 8'hff);
      rc(DCC_MUX_ADDR[i], DCC_MUX_MASK, "mux");
      chk("pins", 8'h00, {4'h0, PLUS_INPUT_SEL[2*i+:2], MINUS_INPUT_SEL[2*i+:2]});
      for (int m = 0; m < 4; m++)
      begin
        acc(1, DCC_MODE_ADDR[i], 8'hf0 | 8'(m));
        chk("speed", 8'(m), {6'h0, RESPONSE_SPEED_SEL[2*i+:2]});
      end
      rc(DCC_MODE_ADDR[i], 8'h33, "mode");
      vp[8*i+:8] <= 8'h80 | hy;
      vn[8*i+:8] <= hy & 8'h7f;
      repeat (4) @(posedge CLK);
      chk("rise", 8'h0b, st(i));
      chk("enable", 8'(1 << i), {6'h0, COMP_ON});
      chk("reset request", 8'(i == 0), {7'h0, COMP_RESET_REQ});
      rc(DCC_CTRL_ADDR[i], ctl(1, 1, 0, hy[3:0]), "control");
      vp[8*i+:8] <= 8'h00;
      vn[8*i+:8] <= 8'h00;
      repeat (4) @(posedge CLK);
      chk("fall", 8'h0c, st(i));
      rc(DCC_CTRL_ADDR[i], ctl(0, 1, 1, hy[3:0]), "control");
      acc(1, DCC_MODE_ADDR[i], 8'h00);
      chk("masked", 8'h00, st(i));
      acc(1, DCC_CTRL_ADDR[i], 8'h00);
      vp[8*i+:8] <= 8'hff;
      repeat (4) @(posedge CLK);
      rc(DCC_CTRL_ADDR[i], 8'h00, "control");
      chk("off", 8'h00, st(i));
      chk("enable", 8'h00, {6'h0, COMP_ON});
      vp[8*i+:8] <= 8'h00;
    end
    conclude();
  end
endmodule
